/* File: hw/adc_injection_and_irq_logic.sv */
`timescale 1ns/1ps
module adc_injection_and_irq_logic (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         nrst,
    // APB register port
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [adc_seq_pkg::ADDR_W-1:0] paddr,
    input  wire logic [adc_seq_pkg::DATA_W-1:0] pwdata,
    output logic      [adc_seq_pkg::DATA_W-1:0] prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Converter core
    output logic                              scan_start,
    output logic                              inj_start,
    output adc_seq_pkg::inj_cfg_t             inj_cfg,
    input  wire logic                         scan_end,
    input  wire logic                         inj_end,
    input  wire adc_seq_pkg::inj_answer_t     inj_answer,
    // Digital fabric
    input  wire logic                         fabric_trig,
    output logic                              scan_done_fabric,
    // Interrupt
    output logic                              irq
);

    localparam int NF = adc_seq_pkg::NUM_FLAGS;

    adc_seq_pkg::seq_state_t state_q;
    adc_seq_pkg::inj_cfg_t   cfg_q;
    logic                    go_q;
    logic                    follow_q;
    logic                    en_q;
    logic                    cont_q;
    logic                    level_q;
    logic                    fabout_q;
    logic                    sw_q;
    logic                    sw_serv_q;
    logic                    fab_pend_q;
    logic                    fab_s1_q;
    logic                    fab_s2_q;
    logic                    fab_s3_q;
    logic [NF-1:0]           flags_q;
    logic [NF-1:0]           flags_d;
    logic [NF-1:0]           enables_q;
    logic [NF-1:0]           set_ev;
    logic [15:0]             result_q;
    logic [1:0]              fab_cnt_q;
    logic                    fab_out_q;
    logic                    scan_start_q;
    logic                    inj_start_q;
    logic                    irq_q;
    logic [31:0]             prdata_q;
    logic                    pready_q;
    logic                    pslverr_q;
    logic [31:0]             rd_data;
    logic                    rd_hit;
    logic                    wr_acc;
    logic                    wr_setup;
    logic                    wr_ctrl;
    logic                    wr_flags;
    logic                    wr_force;
    logic                    wr_enables;
    logic                    go_wr;
    logic                    sw_wr;
    logic                    busy;
    logic                    fab_rise;
    logic                    fab_pulse_ev;
    logic                    fab_level_on;
    logic                    inj_now;
    logic                    take_fab;
    logic                    take_sw;
    logic                    scan_fin;
    logic                    inj_fin;
    logic [NF-1:0]           gated;

    // Bus decode; a write lands on the access edge with pready high
    assign wr_acc     = psel & penable & pready_q & pwrite;
    assign wr_setup   = wr_acc && (paddr == adc_seq_pkg::OFF_INJ_SETUP);
    assign wr_ctrl    = wr_acc && (paddr == adc_seq_pkg::OFF_SEQ_CTRL);
    assign wr_flags   = wr_acc && (paddr == adc_seq_pkg::OFF_IRQ_FLAGS);
    assign wr_force   = wr_acc && (paddr == adc_seq_pkg::OFF_IRQ_FORCE);
    assign wr_enables = wr_acc && (paddr == adc_seq_pkg::OFF_IRQ_ENABLES);
    assign go_wr      = wr_setup & pwdata[adc_seq_pkg::SETUP_GO_BIT];
    assign sw_wr      = wr_ctrl & pwdata[adc_seq_pkg::CTRL_SW_BIT];

    // Sequencer conditions
    assign busy         = (state_q != adc_seq_pkg::SEQ_IDLE);
    assign fab_rise     = fab_s2_q & ~fab_s3_q;
    assign fab_pulse_ev = en_q & ~level_q & fab_rise;
    assign fab_level_on = level_q & fab_s2_q;
    assign scan_fin     = (state_q == adc_seq_pkg::SEQ_SCAN) & scan_end;
    assign inj_fin      = (state_q == adc_seq_pkg::SEQ_INJ) & inj_end;
    assign inj_now      = (state_q == adc_seq_pkg::SEQ_IDLE) & en_q
                          & go_q & ~follow_q;
    assign take_fab     = (state_q == adc_seq_pkg::SEQ_IDLE) & en_q & ~inj_now
                          & (fab_pend_q | fab_level_on);
    assign take_sw      = (state_q == adc_seq_pkg::SEQ_IDLE) & en_q & ~inj_now
                          & ~take_fab & sw_q & ~sw_serv_q;
    assign gated        = flags_q & enables_q;

    // Fabric trigger synchroniser and edge history
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fab_s1_q <= 1'b0;
            fab_s2_q <= 1'b0;
            fab_s3_q <= 1'b0;
        end else begin
            fab_s1_q <= fabric_trig;
            fab_s2_q <= fab_s1_q;
            fab_s3_q <= fab_s2_q;
        end
    end

    // Injection setup register; go is set by firmware only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q    <= '0;
            follow_q <= 1'b0;
            go_q     <= 1'b0;
        end else begin
            if (wr_setup) begin
                cfg_q.input_sel      <= pwdata[adc_seq_pkg::SETUP_SEL_LSB +: 4];
                cfg_q.differential   <= pwdata[adc_seq_pkg::SETUP_DIFF_BIT];
                cfg_q.averaging      <= pwdata[adc_seq_pkg::SETUP_AVG_BIT];
                cfg_q.alt_resolution <= pwdata[adc_seq_pkg::SETUP_ALT_BIT];
                cfg_q.sample_time    <= pwdata[adc_seq_pkg::SETUP_STIME_LSB +: 2];
                follow_q <= pwdata[adc_seq_pkg::SETUP_FOLLOW_BIT];
            end
            if (go_wr) begin
                go_q <= 1'b1;
            end else if (!en_q || inj_fin) begin
                go_q <= 1'b0;
            end
        end
    end

    // Sequencer control register and firmware scan trigger
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_q     <= 1'b0;
            cont_q   <= 1'b0;
            level_q  <= 1'b0;
            fabout_q <= 1'b0;
            sw_q     <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                en_q     <= pwdata[adc_seq_pkg::CTRL_EN_BIT];
                cont_q   <= pwdata[adc_seq_pkg::CTRL_CONT_BIT];
                level_q  <= pwdata[adc_seq_pkg::CTRL_LEVEL_BIT];
                fabout_q <= pwdata[adc_seq_pkg::CTRL_FABOUT_BIT];
            end
            if (sw_wr) begin
                sw_q <= 1'b1;
            end else if (!en_q || (scan_fin && (sw_serv_q || cont_q))) begin
                sw_q <= 1'b0;
            end
        end
    end

    // Pending fabric pulse, held until a scan is started for it or the sequencer is disabled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fab_pend_q <= 1'b0;
        end else if (fab_pulse_ev) begin
            fab_pend_q <= 1'b1;
        end else if (!en_q || take_fab) begin
            fab_pend_q <= 1'b0;
        end
    end

    // Scan and injection scheduler
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q      <= adc_seq_pkg::SEQ_IDLE;
            scan_start_q <= 1'b0;
            inj_start_q  <= 1'b0;
            sw_serv_q    <= 1'b0;
        end else begin
            scan_start_q <= 1'b0;
            inj_start_q  <= 1'b0;
            unique case (state_q)
                adc_seq_pkg::SEQ_IDLE: begin
                    if (inj_now) begin
                        state_q     <= adc_seq_pkg::SEQ_INJ;
                        inj_start_q <= 1'b1;
                    end else if (take_fab || take_sw) begin
                        state_q      <= adc_seq_pkg::SEQ_SCAN;
                        scan_start_q <= 1'b1;
                        sw_serv_q    <= take_sw;
                    end else if (en_q && cont_q) begin
                        state_q      <= adc_seq_pkg::SEQ_SCAN;
                        scan_start_q <= 1'b1;
                    end
                end
                adc_seq_pkg::SEQ_SCAN: begin
                    if (sw_wr) begin
                        sw_serv_q <= 1'b0;
                    end
                    if (scan_end) begin
                        sw_serv_q <= 1'b0;
                        if (go_q && en_q) begin
                            state_q     <= adc_seq_pkg::SEQ_INJ;
                            inj_start_q <= 1'b1;
                        end else begin
                            state_q <= adc_seq_pkg::SEQ_IDLE;
                        end
                    end
                end
                adc_seq_pkg::SEQ_INJ: begin
                    if (inj_end) begin
                        state_q <= adc_seq_pkg::SEQ_IDLE;
                    end
                end
                default: begin
                    state_q <= adc_seq_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // Hardware events that set interrupt flags
    always_comb begin
        set_ev = '0;
        set_ev[adc_seq_pkg::FLG_SCAN_DONE] = scan_fin;
        set_ev[adc_seq_pkg::FLG_OVERRUN]   = scan_fin
            & flags_q[adc_seq_pkg::FLG_SCAN_DONE];
        set_ev[adc_seq_pkg::FLG_SW_CLASH]  = sw_wr & en_q & busy;
        set_ev[adc_seq_pkg::FLG_FAB_CLASH] = fab_pulse_ev & busy;
        set_ev[adc_seq_pkg::FLG_INJ_CLASH] = go_wr & en_q
            & ~pwdata[adc_seq_pkg::SETUP_FOLLOW_BIT]
            & (state_q == adc_seq_pkg::SEQ_SCAN);
        set_ev[adc_seq_pkg::FLG_INJ_DONE]   = inj_fin;
        set_ev[adc_seq_pkg::FLG_INJ_WINDOW] = inj_fin & inj_answer.window;
        set_ev[adc_seq_pkg::FLG_INJ_CLIP]   = inj_fin & inj_answer.clip;
    end

    // Flags: write-one clears, force and events set, set wins
    always_comb begin
        flags_d = flags_q;
        if (wr_flags) begin
            flags_d = flags_d & ~pwdata[NF-1:0];
        end
        if (wr_force) begin
            flags_d = flags_d | pwdata[NF-1:0];
        end
        flags_d = flags_d | set_ev;
    end

    // Flag and enable registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_q   <= adc_seq_pkg::FLAGS_RST;
            enables_q <= adc_seq_pkg::ENABLES_RST;
        end else begin
            flags_q <= flags_d;
            if (wr_enables) begin
                enables_q <= pwdata[NF-1:0];
            end
        end
    end

    // Injection result capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result_q <= adc_seq_pkg::RESULT_RST;
        end else if (inj_fin) begin
            result_q <= inj_answer.value;
        end
    end

    // Scan done strobe toward the fabric; injection never reaches it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fab_out_q <= 1'b0;
            fab_cnt_q <= 2'h0;
        end else if (scan_fin && fabout_q) begin
            fab_out_q <= 1'b1;
            fab_cnt_q <= adc_seq_pkg::FAB_DONE_CYCLES - 2'h1;
        end else if (fab_cnt_q != 2'h0) begin
            fab_cnt_q <= fab_cnt_q - 2'h1;
        end else begin
            fab_out_q <= 1'b0;
        end
    end

    // Interrupt line from the gated view
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |gated;
        end
    end

    // Read data selection
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (paddr)
            adc_seq_pkg::OFF_INJ_SETUP: begin
                rd_data[adc_seq_pkg::SETUP_SEL_LSB +: 4]   = cfg_q.input_sel;
                rd_data[adc_seq_pkg::SETUP_DIFF_BIT]       = cfg_q.differential;
                rd_data[adc_seq_pkg::SETUP_AVG_BIT]        = cfg_q.averaging;
                rd_data[adc_seq_pkg::SETUP_ALT_BIT]        = cfg_q.alt_resolution;
                rd_data[adc_seq_pkg::SETUP_STIME_LSB +: 2] = cfg_q.sample_time;
                rd_data[adc_seq_pkg::SETUP_FOLLOW_BIT]     = follow_q;
                rd_data[adc_seq_pkg::SETUP_GO_BIT]         = go_q;
            end
            adc_seq_pkg::OFF_INJ_RESULT: begin
                rd_data[15:0] = result_q;
                rd_data[adc_seq_pkg::RES_VALID_BIT] =
                    flags_q[adc_seq_pkg::FLG_INJ_DONE];
                rd_data[adc_seq_pkg::RES_WINDOW_BIT] =
                    flags_q[adc_seq_pkg::FLG_INJ_WINDOW];
                rd_data[adc_seq_pkg::RES_CLIP_BIT] =
                    flags_q[adc_seq_pkg::FLG_INJ_CLIP];
                rd_data[adc_seq_pkg::RES_CLASH_BIT] =
                    flags_q[adc_seq_pkg::FLG_INJ_CLASH];
            end
            adc_seq_pkg::OFF_IRQ_FLAGS,
            adc_seq_pkg::OFF_IRQ_FORCE: rd_data[NF-1:0] = flags_q;
            adc_seq_pkg::OFF_IRQ_ENABLES: rd_data[NF-1:0] = enables_q;
            adc_seq_pkg::OFF_IRQ_GATED: rd_data[NF-1:0] = gated;
            adc_seq_pkg::OFF_SEQ_CTRL: begin
                rd_data[adc_seq_pkg::CTRL_EN_BIT]     = en_q;
                rd_data[adc_seq_pkg::CTRL_CONT_BIT]   = cont_q;
                rd_data[adc_seq_pkg::CTRL_LEVEL_BIT]  = level_q;
                rd_data[adc_seq_pkg::CTRL_SW_BIT]     = sw_q;
                rd_data[adc_seq_pkg::CTRL_FABOUT_BIT] = fabout_q;
            end
            adc_seq_pkg::OFF_SEQ_STATUS: begin
                rd_data[1:0] = state_q;
                rd_data[2]   = fab_pend_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // APB answer: one access cycle, data latched in the setup cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q  <= rd_data;
            pready_q  <= 1'b1;
            pslverr_q <= ~rd_hit;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Outputs straight from flip-flops
    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign scan_start       = scan_start_q;
    assign inj_start        = inj_start_q;
    assign inj_cfg          = cfg_q;
    assign scan_done_fabric = fab_out_q;
    assign irq              = irq_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    inj_only_go_a: assert property ($rose(inj_start_q) |-> go_q)
        else $error("Injection started without a go request");
    inj_end_a: assert property (inj_fin |=>
        flags_q[adc_seq_pkg::FLG_INJ_DONE] && (result_q == $past(inj_answer.value)))
        else $error("Injection end did not store result and done flag");
    tail_follow_a: assert property (scan_fin && go_q && en_q && follow_q |=>
        state_q == adc_seq_pkg::SEQ_INJ && inj_start_q
        && !$rose(flags_q[adc_seq_pkg::FLG_INJ_CLASH]))
        else $error("Follow-scan injection did not start cleanly");
    direct_start_a: assert property (inj_now |=>
        state_q == adc_seq_pkg::SEQ_INJ ##0 inj_start_q ##1 !inj_start_q)
        else $error("Idle injection did not start at once");
    inj_clash_a: assert property (set_ev[adc_seq_pkg::FLG_INJ_CLASH] |=>
        flags_q[adc_seq_pkg::FLG_INJ_CLASH])
        else $error("Injection clash flag not set");
    disable_drop_a: assert property (!en_q && go_q && !go_wr |=> !go_q)
        else $error("Go request survived a disabled converter");
    irq_gate_a: assert property (1'b1 |=> irq_q == $past(|gated))
        else $error("Interrupt does not follow gated flags");
    overrun_a: assert property (scan_fin && flags_q[adc_seq_pkg::FLG_SCAN_DONE]
        |=> flags_q[adc_seq_pkg::FLG_OVERRUN])
        else $error("Overrun not flagged");
    fab_two_a: assert property ($rose(fab_out_q) |=> fab_out_q)
        else $error("Fabric scan done shorter than two cycles");
    post_inj_a: assert property (sw_wr && en_q &&
        state_q == adc_seq_pkg::SEQ_INJ |=>
        flags_q[adc_seq_pkg::FLG_SW_CLASH] && !scan_start_q)
        else $error("Trigger during injection not held back");

    tail_path_c: cover property (scan_fin && go_q && follow_q);
    direct_path_c: cover property (inj_now);
    overrun_c: cover property (set_ev[adc_seq_pkg::FLG_OVERRUN]);
    fab_clash_c: cover property (set_ev[adc_seq_pkg::FLG_FAB_CLASH]);

endmodule

/* File: shared/adc_seq_pkg.sv */
package adc_seq_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_INJ_SETUP   = 8'h00;
    localparam logic [7:0] OFF_INJ_RESULT  = 8'h04;
    localparam logic [7:0] OFF_IRQ_FLAGS   = 8'h08;
    localparam logic [7:0] OFF_IRQ_FORCE   = 8'h0c;
    localparam logic [7:0] OFF_IRQ_ENABLES = 8'h10;
    localparam logic [7:0] OFF_IRQ_GATED   = 8'h14;
    localparam logic [7:0] OFF_SEQ_CTRL    = 8'h18;
    localparam logic [7:0] OFF_SEQ_STATUS  = 8'h1c;

    // Injection setup field positions
    localparam int SETUP_SEL_LSB    = 0;
    localparam int SETUP_DIFF_BIT   = 8;
    localparam int SETUP_AVG_BIT    = 9;
    localparam int SETUP_ALT_BIT    = 10;
    localparam int SETUP_STIME_LSB  = 12;
    localparam int SETUP_FOLLOW_BIT = 30;
    localparam int SETUP_GO_BIT     = 31;

    // Injection result field positions
    localparam int RES_CLASH_BIT  = 28;
    localparam int RES_CLIP_BIT   = 29;
    localparam int RES_WINDOW_BIT = 30;
    localparam int RES_VALID_BIT  = 31;

    // Sequencer control field positions
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_CONT_BIT   = 1;
    localparam int CTRL_LEVEL_BIT  = 2;
    localparam int CTRL_SW_BIT     = 3;
    localparam int CTRL_FABOUT_BIT = 31;

    // Interrupt flag positions
    localparam int NUM_FLAGS      = 8;
    localparam int FLG_SCAN_DONE  = 0;
    localparam int FLG_OVERRUN    = 1;
    localparam int FLG_SW_CLASH   = 2;
    localparam int FLG_FAB_CLASH  = 3;
    localparam int FLG_INJ_CLASH  = 4;
    localparam int FLG_INJ_DONE   = 5;
    localparam int FLG_INJ_WINDOW = 6;
    localparam int FLG_INJ_CLIP   = 7;

    // Values after reset
    localparam logic [NUM_FLAGS-1:0] FLAGS_RST   = 8'h00;
    localparam logic [NUM_FLAGS-1:0] ENABLES_RST = 8'h00;
    localparam logic [15:0]          RESULT_RST  = 16'h0000;

    // Cycles the scan done flag stands on the fabric
    localparam logic [1:0] FAB_DONE_CYCLES = 2'h2;

    // Injection conversion setup handed to the converter core
    typedef struct packed {
        logic [3:0] input_sel;
        logic       differential;
        logic       averaging;
        logic       alt_resolution;
        logic [1:0] sample_time;
    } inj_cfg_t;

    // Answer of the converter core for one injection conversion
    typedef struct packed {
        logic [15:0] value;
        logic        window;
        logic        clip;
    } inj_answer_t;

    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SCAN = 2'b01,
        SEQ_INJ  = 2'b10
    } seq_state_t;

endpackage

/* File: test/core_model.sv */
`timescale 1ns/1ps
module core_model #(
    parameter logic [3:0]  SCAN_LEN = 4'hc,
    parameter logic [3:0]  INJ_LEN  = 4'h5,
    parameter logic [17:0] ANSWER   = 18'h02af2
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Job requests
    input  wire logic                 scan_start,
    input  wire logic                 inj_start,
    // Job answers
    output logic                      scan_end,
    output logic                      inj_end,
    output adc_seq_pkg::inj_answer_t  inj_answer
);
    logic [3:0] scan_cnt_q;
    logic [3:0] inj_cnt_q;
    // Scan of all channels takes a fixed count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) scan_cnt_q <= 4'h0;
        else if (scan_start) scan_cnt_q <= SCAN_LEN;
        else if (scan_cnt_q != 4'h0) scan_cnt_q <= scan_cnt_q - 4'h1;
    end
    // Injection conversion takes a fixed count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) inj_cnt_q <= 4'h0;
        else if (inj_start) inj_cnt_q <= INJ_LEN;
        else if (inj_cnt_q != 4'h0) inj_cnt_q <= inj_cnt_q - 4'h1;
    end
    // Answer is only meaningful with the end strobe
    assign scan_end   = (scan_cnt_q == 4'h1);
    assign inj_end    = (inj_cnt_q == 4'h1);
    assign inj_answer = inj_end ? ANSWER : ~ANSWER;
endmodule

/* File: test/adc_injection_and_irq_logic_tb.sv */
`timescale 1ns/1ps
module adc_injection_and_irq_logic_tb;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, rerr, irq;
    logic scan_start, inj_start, scan_end, inj_end, fabric_trig, fab_done;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    adc_seq_pkg::inj_cfg_t    inj_cfg;
    adc_seq_pkg::inj_answer_t inj_answer;
    int n_errors, cmp_count, fab_hi = 0;
    // Design and converter model
    adc_injection_and_irq_logic uut (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scan_start(scan_start), .inj_start(inj_start), .inj_cfg(inj_cfg),
        .scan_end(scan_end), .inj_end(inj_end), .inj_answer(inj_answer),
        .fabric_trig(fabric_trig), .scan_done_fabric(fab_done), .irq(irq));
    core_model core (.clk(clk), .nrst(nrst), .scan_start(scan_start),
        .inj_start(inj_start), .scan_end(scan_end), .inj_end(inj_end),
        .inj_answer(inj_answer));
    // Clock of 40 ns
    always #20 clk = ~clk;
    // Cycles in which scan done stands on the fabric
    always @(posedge clk) if (fab_done === 1'b1) fab_hi <= fab_hi + 1;
    task automatic close_out;
        $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_irq(input logic e);
        @(negedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    // One transfer, started after a rising edge; the answer is the value
    // that stands at the access edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        logic ok;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            ok   = pready;
            rdat = prdata;
            rerr = pslverr;
            @(posedge clk);
            n++;
        end while (ok !== 1'b1 && n < 50);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("Error pready expected 1 seen %b", ok);
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // Poll the flags until all bits of m are up
    task automatic wait_flag(input logic [7:0] m);
        int n;
        n = 0;
        do begin
            rd(adc_seq_pkg::OFF_IRQ_FLAGS);
            n++;
        end while ((rdat[7:0] & m) !== m && n < 200);
        if (n >= 200) begin
            n_errors++;
            $display("Error flags expected %h seen %h", m, rdat[7:0]);
            close_out();
        end
    endtask
    // Main sequence
    initial begin
        clk = 0;
        nrst = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fabric_trig = 0;
        n_errors = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(adc_seq_pkg::OFF_IRQ_FLAGS);
        chk("flags", 32'h0, rdat);
        rd(8'h20);
        chk("pslverr", 32'h1, {31'h0, rerr});
        wr(adc_seq_pkg::OFF_SEQ_CTRL, 32'h1);
        wr(adc_seq_pkg::OFF_IRQ_ENABLES, 32'hff);
        // Follow-scan request waits for a scan
        wr(adc_seq_pkg::OFF_INJ_SETUP, 32'hc0000003);
        repeat (30) @(posedge clk);
        rd(adc_seq_pkg::OFF_INJ_SETUP);
        chk("setup", 32'hc0000003, rdat);
        wr(adc_seq_pkg::OFF_SEQ_CTRL, 32'h9);
        wait_flag(8'h20);
        rd(adc_seq_pkg::OFF_IRQ_FLAGS);
        chk("flags", 32'h61, rdat);
        rd(adc_seq_pkg::OFF_INJ_RESULT);
        chk("result", 32'hc0000abc, rdat);
        rd(adc_seq_pkg::OFF_INJ_SETUP);
        chk("setup", 32'h40000003, rdat);
        chk_irq(1'b1);
        wr(adc_seq_pkg::OFF_IRQ_FLAGS, 32'hff);
        rd(adc_seq_pkg::OFF_IRQ_FLAGS);
        chk("flags", 32'h0, rdat);
        chk_irq(1'b0);
        // Direct injection while idle, firmware trigger held behind it
        wr(adc_seq_pkg::OFF_INJ_SETUP, 32'h80003705);
        wr(adc_seq_pkg::OFF_SEQ_CTRL, 32'h9);
        wait_flag(8'h21);
        chk("flags", 32'h65, rdat);
        chk("cfg", 32'h0bf, {23'h0, inj_cfg});
        wr(adc_seq_pkg::OFF_IRQ_FLAGS, 32'hff);
        // Requests during a scan: clashes and overrun
        wr(adc_seq_pkg::OFF_SEQ_CTRL, 32'h9);
        wr(adc_seq_pkg::OFF_INJ_SETUP, 32'h80000000);
        wr(adc_seq_pkg::OFF_SEQ_CTRL, 32'h9);
        wait_flag(8'h02);
        chk("flags", 32'h77, rdat);
        rd(adc_seq_pkg::OFF_INJ_RESULT);
        chk("result", 32'hd0000abc, rdat);
        wr(adc_seq_pkg::OFF_IRQ_FLAGS, 32'hff);
        // Fabric pulse during a scan, scan done shown on the fabric
        wr(adc_seq_pkg::OFF_SEQ_CTRL, 32'h80000009);
        fabric_trig <= 1'b1;
        repeat (4) @(posedge clk);
        fabric_trig <= 1'b0;
        wait_flag(8'h0b);
        chk("flags", 32'h0b, rdat);
        wr(adc_seq_pkg::OFF_IRQ_FLAGS, 32'hff);
        chk("fabric", 32'd4, fab_hi);
        // Level fabric trigger starts scans and never clashes
        wr(adc_seq_pkg::OFF_SEQ_CTRL, 32'h5);
        fabric_trig <= 1'b1;
        wait_flag(8'h03);
        fabric_trig <= 1'b0;
        chk("clash", 32'h0, rdat & 32'h0c);
        repeat (40) @(posedge clk);
        wr(adc_seq_pkg::OFF_IRQ_FLAGS, 32'hff);
        // Forced flag with and without its enable
        wr(adc_seq_pkg::OFF_IRQ_ENABLES, 32'h0f);
        wr(adc_seq_pkg::OFF_IRQ_FORCE, 32'h80);
        rd(adc_seq_pkg::OFF_IRQ_GATED);
        chk("gated", 32'h0, rdat);
        rd(adc_seq_pkg::OFF_IRQ_FLAGS);
        chk("flags", 32'h80, rdat);
        chk_irq(1'b0);
        wr(adc_seq_pkg::OFF_IRQ_ENABLES, 32'hff);
        rd(adc_seq_pkg::OFF_IRQ_GATED);
        chk("gated", 32'h80, rdat);
        chk_irq(1'b1);
        wr(adc_seq_pkg::OFF_IRQ_FLAGS, 32'hff);
        // Go request dropped while disabled
        wr(adc_seq_pkg::OFF_SEQ_CTRL, 32'h0);
        wr(adc_seq_pkg::OFF_INJ_SETUP, 32'h80000000);
        repeat (2) @(posedge clk);
        rd(adc_seq_pkg::OFF_INJ_SETUP);
        chk("setup", 32'h0, rdat);
        rd(adc_seq_pkg::OFF_IRQ_FLAGS);
        chk("flags", 32'h0, rdat);
        close_out();
    end
endmodule
